// [ccsl_consts.vh]
// Purpose: constants for the charger control and status logic
// Assumes: 32-bit AHB-Lite register words, 200 MHz hclk
// Notes:   offsets are byte addresses of aligned words
`ifndef CCSL_CONSTS_VH
`define CCSL_CONSTS_VH

`define CCSL_OFF_CFG       12'h000
`define CCSL_OFF_LIMITS    12'h004
`define CCSL_OFF_BOOST     12'h008
`define CCSL_OFF_STATUS    12'h00C
`define CCSL_OFF_FAULT     12'h010

// CFG word fields
`define CCSL_CFG_ILIM_BIT  0
`define CCSL_CFG_SYSMIN_LO 1
`define CCSL_CFG_CHG_LO    4
`define CCSL_CFG_RECHG_BIT 8
`define CCSL_CFG_SWOFF_BIT 9
`define CCSL_CFG_RST       32'h0000001A

// LIMITS word fields (charge voltage, fast, pre, term codes)
`define CCSL_LIM_RST       32'h0041A777

// BOOST word fields
`define CCSL_BST_HOT_LO    2
`define CCSL_BST_V_LO      4
`define CCSL_BST_RST       32'h00000090

// STATUS word fields
`define CCSL_ST_SYSMIN_BIT 0
`define CCSL_ST_DPM_BIT    3
`define CCSL_ST_PHASE_LO   4
`define CCSL_ST_SRC_LO     6

`define CCSL_FLT_BOOST_BIT 6

`define CCSL_CHG_DISABLE   2'h0
`define CCSL_CHG_ENABLE    2'h1
`define CCSL_CHG_BOOST     2'h2
`define CCSL_HOT_OFF       2'h3

`define CCSL_PH_DIS        2'h0
`define CCSL_PH_PRE        2'h1
`define CCSL_PH_FAST       2'h2
`define CCSL_PH_DONE       2'h3
`define CCSL_SRC_BOOST     2'h3

// Times
`define CCSL_CLK_MHZ       200
`define CCSL_BOOST_WAIT_MS 30
`define CCSL_BOOST_WAIT_CYC (`CCSL_BOOST_WAIT_MS * `CCSL_CLK_MHZ * 1000)
`define CCSL_BLINK_MS      500
`define CCSL_BLINK_CYC     (`CCSL_BLINK_MS * `CCSL_CLK_MHZ * 1000)
`define CCSL_ALERT_CYC     16

`endif

// [ccsl_sync.v]
// Purpose: two-flop synchroniser for a bundle of comparator levels
// Assumes: inputs are quasi-static analog comparator results
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module ccsl_sync
#(
  parameter WIDTH = 1
)
(
  input  wire             hclk,
  input  wire             hresetn,
  input  wire             ce,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else if (ce)
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// [ccsl_top.v]
// Purpose: control and status logic of a single-cell charger
// Assumes: AHB-Lite slave, single word transfers, 200 MHz hclk
// Notes:   analog loops are outside; comparator results come in as pins
// Overview of operation
// - Boost allowed only with request pin, config 10, battery ok, bus low.
// - Temperature outside boost window blocks boost unless hot select is 11.
// - Boost starts only after 30 ms of continuously met conditions.
// - Source status field reads 11 while boost is active.
// - One config bit picks boost current limit 1 A or 1.5 A.
// - Four-bit field sets boost voltage target 4.55 V to 5.5 V.
// - A boost fault while boost is enabled sets sticky boost fault flag and raises alert.
// - Three-bit field sets minimum system voltage, default 3.5 V.
// - Minimum system regulation status follows the regulation comparator.
// - Input overload cuts charge current until current and voltage recover.
// - Power limiting status high while either input regulation loop active.
// - Supplement on when system below battery, off below depletion.
// - Reset defaults: charge enabled, 4.208 V, 2.048 A, 128/256 mA, 12 h.
// - New cycle needs converter, config 01, enable low, no faults, switch on.
// - Cycle ends when current below termination and battery above recharge, with no input overload.
// - After done, battery below selected recharge threshold restarts charge.
// - Indicator low charging, high done or disabled, blinking on fault.
// - Phase field: 00 disabled, 01 precharge, 10 fast, 11 done.
// - Alert asserted whenever a charge cycle completes.
`timescale 1ns/1ps
`include "ccsl_consts.vh"
module ccsl_top
#(
  parameter BOOST_WAIT_CYC = `CCSL_BOOST_WAIT_CYC,
  parameter BLINK_CYC      = `CCSL_BLINK_CYC,
  parameter ALERT_CYC      = `CCSL_ALERT_CYC
)
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        boost_request_pin,
  input  wire        charge_enable_n,
  input  wire        cmp_bat_above_low,
  input  wire        cmp_bus_below_sleep,
  input  wire        cmp_temp_in_boost_win,
  input  wire        cmp_boost_fault,
  input  wire        cmp_sys_at_min,
  input  wire        cmp_input_current_reg,
  input  wire        cmp_input_voltage_reg,
  input  wire        cmp_sys_below_bat,
  input  wire        cmp_bat_below_depl,
  input  wire        cmp_bat_above_short,
  input  wire        cmp_chg_below_term,
  input  wire        cmp_bat_above_rechg_hi,
  input  wire        cmp_bat_above_rechg_lo,
  input  wire        cmp_converter_on,
  input  wire        cmp_thermistor_fault,
  input  wire        cmp_timer_fault,
  output reg         boost_enable,
  output reg         boost_current_high,
  output reg  [3:0]  boost_voltage_select,
  output reg  [2:0]  sys_min_select,
  output reg         charge_current_cut,
  output reg         battery_switch,
  output reg         charge_active,
  output reg  [31:0] charge_params,
  output reg         stat_out,
  output reg         stat_oe,
  output reg         host_alert_n
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_PRE   = 2'h1;
  localparam ST_FAST  = 2'h2;
  localparam ST_DONE  = 2'h3;

  wire [15:0] syn;

  ccsl_sync #(
    .WIDTH (16)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .async_in ({cmp_timer_fault, cmp_thermistor_fault, cmp_converter_on,
                cmp_bat_above_rechg_lo, cmp_bat_above_rechg_hi,
                cmp_chg_below_term, cmp_bat_above_short,
                cmp_bat_below_depl, cmp_sys_below_bat,
                cmp_input_voltage_reg, cmp_input_current_reg,
                cmp_sys_at_min, cmp_boost_fault, cmp_temp_in_boost_win,
                cmp_bus_below_sleep, cmp_bat_above_low}),
    .sync_out (syn)
  );

  wire s_bat_ok     = syn[0];
  wire s_bus_low    = syn[1];
  wire s_temp_ok    = syn[2];
  wire s_bst_fault  = syn[3];
  wire s_sys_min    = syn[4];
  wire s_iin_reg    = syn[5];
  wire s_vin_reg    = syn[6];
  wire s_sys_lt_bat = syn[7];
  wire s_bat_depl   = syn[8];
  wire s_above_shrt = syn[9];
  wire s_below_term = syn[10];
  wire s_rechg_hi   = syn[11];
  wire s_rechg_lo   = syn[12];
  wire s_conv_on    = syn[13];
  wire s_ts_fault   = syn[14];
  wire s_tmr_fault  = syn[15];

  // Registers
  reg  [31:0] cfg;
  reg  [31:0] limits;
  reg  [31:0] boost_cfg;
  reg         boost_fault_flag;
  reg  [1:0]  state;
  reg  [1:0]  next_state;

  // AHB address phase capture
  reg         dp_valid;
  reg         dp_write;
  reg  [11:0] dp_addr;
  reg  [31:0] rdata;

  wire [1:0]  chg_cfg  = cfg[`CCSL_CFG_CHG_LO+1:`CCSL_CFG_CHG_LO];
  wire [1:0]  hot_sel  = boost_cfg[`CCSL_BST_HOT_LO+1:`CCSL_BST_HOT_LO];
  wire        rechg_sel = cfg[`CCSL_CFG_RECHG_BIT];
  wire        sw_off   = cfg[`CCSL_CFG_SWOFF_BIT];

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata;

  wire addr_phase = hsel && hready && htrans[1];
  wire wr_now     = ce && dp_valid && dp_write;
  wire rd_clr_flt = ce && addr_phase && !hwrite &&
                    haddr == `CCSL_OFF_FAULT;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 12'h000;
    end
    else if (ce)
    begin
      dp_valid <= addr_phase;
      dp_write <= addr_phase && hwrite;
      dp_addr  <= haddr;
    end
  end

  // Register writes; host may rewrite at any time
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg       <= `CCSL_CFG_RST;
      limits    <= `CCSL_LIM_RST;
      boost_cfg <= `CCSL_BST_RST;
    end
    else if (wr_now)
    begin
      case (dp_addr)
        `CCSL_OFF_CFG:    cfg       <= {22'h000000, hwdata[9:0]};
        `CCSL_OFF_LIMITS: limits    <= hwdata;
        `CCSL_OFF_BOOST:  boost_cfg <= {24'h000000, hwdata[7:2], 2'h0};
        default:          cfg       <= cfg;
      endcase
    end
  end

  // Boost qualification
  wire boost_qual = boost_request_pin && chg_cfg == `CCSL_CHG_BOOST &&
                    s_bat_ok && s_bus_low &&
                    (s_temp_ok || hot_sel == `CCSL_HOT_OFF);
  reg  [31:0] bst_cnt;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bst_cnt      <= 32'h00000000;
      boost_enable <= 1'b0;
    end
    else if (ce)
    begin
      if (!boost_qual)
      begin
        bst_cnt      <= 32'h00000000;
        boost_enable <= 1'b0;
      end
      else if (bst_cnt >= BOOST_WAIT_CYC - 1)
        boost_enable <= 1'b1;
      else
        bst_cnt <= bst_cnt + 32'h00000001;
    end
  end

  // Sticky fault; read of fault word clears, a new fault wins
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      boost_fault_flag <= 1'b0;
    else if (ce)
    begin
      if (boost_enable && s_bst_fault)
        boost_fault_flag <= 1'b1;
      else if (rd_clr_flt)
        boost_fault_flag <= 1'b0;
    end
  end

  // Charge cycle
  wire cycle_ok = s_conv_on && chg_cfg == `CCSL_CHG_ENABLE &&
                  !charge_enable_n && !s_ts_fault && !s_tmr_fault &&
                  !sw_off;
  wire above_rechg = rechg_sel ? s_rechg_hi : s_rechg_lo;
  wire overload    = s_iin_reg || s_vin_reg;
  wire term_now    = s_below_term && above_rechg && !overload;

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (cycle_ok)
          next_state = s_bat_ok ? ST_FAST : ST_PRE;
      ST_PRE:
        if (!cycle_ok)
          next_state = ST_IDLE;
        else if (s_bat_ok)
          next_state = ST_FAST;
      ST_FAST:
        if (!cycle_ok)
          next_state = ST_IDLE;
        else if (term_now)
          next_state = ST_DONE;
      ST_DONE:
        if (!cycle_ok)
          next_state = ST_IDLE;
        else if (!above_rechg)
          next_state = s_bat_ok ? ST_FAST : ST_PRE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Charge done and boost fault pulses hold the alert low for a short while
  reg  [7:0]  alert_cnt;
  wire        done_evt = state == ST_FAST && next_state == ST_DONE;
  reg         fault_q;
  wire        fault_evt = boost_enable && s_bst_fault && !fault_q;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state     <= ST_IDLE;
      alert_cnt <= 8'h00;
      fault_q   <= 1'b0;
    end
    else if (ce)
    begin
      state   <= next_state;
      fault_q <= boost_enable && s_bst_fault;
      if (done_evt || fault_evt)
        alert_cnt <= ALERT_CYC[7:0];
      else if (alert_cnt != 8'h00)
        alert_cnt <= alert_cnt - 8'h01;
    end
  end

  // Blink timer for charging fault indication
  reg  [31:0] blink_cnt;
  reg         blink;
  wire        chg_fault = chg_cfg == `CCSL_CHG_ENABLE &&
                          (s_ts_fault || s_tmr_fault);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      blink_cnt <= 32'h00000000;
      blink     <= 1'b0;
    end
    else if (ce)
    begin
      if (blink_cnt >= BLINK_CYC - 1)
      begin
        blink_cnt <= 32'h00000000;
        blink     <= !blink;
      end
      else
        blink_cnt <= blink_cnt + 32'h00000001;
    end
  end

  // Outputs from flops
  wire [1:0] src_stat = boost_enable ? `CCSL_SRC_BOOST : 2'h0;
  wire [31:0] status_word = {24'h000000, src_stat, state, overload,
                             2'h0, s_sys_min};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      boost_current_high   <= 1'b0;
      boost_voltage_select <= 4'h0;
      sys_min_select       <= 3'h0;
      charge_current_cut   <= 1'b0;
      battery_switch       <= 1'b0;
      charge_active        <= 1'b0;
      charge_params        <= 32'h00000000;
      stat_out             <= 1'b0;
      stat_oe              <= 1'b0;
      host_alert_n         <= 1'b1;
      rdata                <= 32'h00000000;
    end
    else if (ce)
    begin
      boost_current_high   <= cfg[`CCSL_CFG_ILIM_BIT];
      boost_voltage_select <= boost_cfg[`CCSL_BST_V_LO+3:`CCSL_BST_V_LO];
      sys_min_select       <= cfg[`CCSL_CFG_SYSMIN_LO+2:`CCSL_CFG_SYSMIN_LO];
      charge_current_cut   <= overload;
      if (sw_off || s_bat_depl)
        battery_switch <= 1'b0;
      else if (s_sys_lt_bat || state == ST_PRE || state == ST_FAST)
        battery_switch <= 1'b1;
      else
        battery_switch <= 1'b0;
      charge_active        <= next_state == ST_PRE || next_state == ST_FAST;
      charge_params        <= limits;
      // Open drain: enable pulls low, released reads high
      if (chg_fault)
        stat_oe <= blink;
      else
        stat_oe <= next_state == ST_PRE || next_state == ST_FAST;
      stat_out     <= 1'b0;
      host_alert_n <= !(done_evt || fault_evt || alert_cnt != 8'h00);
      if (addr_phase && !hwrite)
      begin
        case (haddr)
          `CCSL_OFF_CFG:    rdata <= cfg;
          `CCSL_OFF_LIMITS: rdata <= limits;
          `CCSL_OFF_BOOST:  rdata <= boost_cfg;
          `CCSL_OFF_STATUS: rdata <= status_word;
          `CCSL_OFF_FAULT:
            rdata <= {25'h0000000, boost_fault_flag, 6'h00};
          default:          rdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// [ccsl_top_asserts.sv]
// Purpose: port-level checks for ccsl_top
// Assumes: ce held high, comparators pass a 2-flop sync
// Notes:   bound to ccsl_top at the foot of this file
`timescale 1ns/1ps
module ccsl_top_asserts
#(
  parameter BOOST_WAIT_CYC = 20
)
(
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire boost_request_pin,
  input wire cmp_bat_above_low,
  input wire cmp_bus_below_sleep,
  input wire cmp_boost_fault,
  input wire cmp_input_current_reg,
  input wire cmp_input_voltage_reg,
  input wire cmp_sys_below_bat,
  input wire cmp_bat_below_depl,
  input wire boost_enable,
  input wire charge_current_cut,
  input wire battery_switch,
  input wire charge_active,
  input wire stat_oe,
  input wire host_alert_n
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Saturates so a long request never wraps
  integer req_run;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      req_run <= 0;
    else if (!boost_request_pin)
      req_run <= 0;
    else if (req_run < BOOST_WAIT_CYC + 8)
      req_run <= req_run + 1;
  property p_boost_qual;
    $rose(boost_enable) |-> $past(boost_request_pin, 3) &&
      $past(cmp_bat_above_low, 3) && $past(cmp_bus_below_sleep, 3);
  endproperty
  a_boost_qual: assert property (p_boost_qual)
    else $error("boost started without qualification");
  property p_boost_drop;
    !boost_request_pin [*6] |-> !boost_enable;
  endproperty
  a_boost_drop: assert property (p_boost_drop)
    else $error("boost still on without request");
  property p_boost_wait;
    $rose(boost_enable) |-> req_run >= BOOST_WAIT_CYC;
  endproperty
  a_boost_wait: assert property (p_boost_wait)
    else $error("boost started before wait elapsed");
  property p_boost_fault;
    $rose(cmp_boost_fault) |-> ##[1:5] !host_alert_n;
  endproperty
  a_boost_fault: assert property (p_boost_fault)
    else $error("no alert after boost fault");
  property p_cut_on;
    $rose(cmp_input_current_reg) |-> ##[1:5] charge_current_cut;
  endproperty
  a_cut_on: assert property (p_cut_on)
    else $error("overload did not cut charge");
  property p_cut_off;
    (!cmp_input_current_reg && !cmp_input_voltage_reg) [*6]
      |-> !charge_current_cut;
  endproperty
  a_cut_off: assert property (p_cut_off)
    else $error("charge cut held after recovery");
  property p_supp_on;
    (cmp_sys_below_bat && !cmp_bat_below_depl) [*6] |-> battery_switch;
  endproperty
  a_supp_on: assert property (p_supp_on)
    else $error("switch off while system below battery");
  property p_supp_off;
    (cmp_bat_below_depl && !charge_active) [*6] |-> !battery_switch;
  endproperty
  a_supp_off: assert property (p_supp_off)
    else $error("switch on with depleted battery");
  property p_stat;
    charge_active [*3] |-> stat_oe;
  endproperty
  a_stat: assert property (p_stat)
    else $error("indicator not low while charging");
  property p_alert_len;
    $fell(host_alert_n) |-> !host_alert_n [*8];
  endproperty
  a_alert_len: assert property (p_alert_len)
    else $error("alert pulse too short");
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus not ready or not okay");
endmodule

bind ccsl_top ccsl_top_asserts #(.BOOST_WAIT_CYC(BOOST_WAIT_CYC)) chk_i
(
  .hclk, .hresetn, .hreadyout, .hresp, .boost_request_pin,
  .cmp_bat_above_low, .cmp_bus_below_sleep, .cmp_boost_fault,
  .cmp_input_current_reg, .cmp_input_voltage_reg, .cmp_sys_below_bat,
  .cmp_bat_below_depl, .boost_enable, .charge_current_cut,
  .battery_switch, .charge_active, .stat_oe, .host_alert_n
);

// [ccsl_host.sv]
// Purpose: host model, AHB-Lite master for single word transfers
// Assumes: one slave whose hreadyout is hready
// Notes:   waits on hready with no cycle count of its own
`timescale 1ns/1ps
module ccsl_host
(
  input  wire         hclk,
  input  wire         hready,
  input  wire  [31:0] hrdata,
  output logic        hsel,
  output logic [11:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    {hsel, haddr, htrans, hwrite, hsize} = '0;
    hwdata = 32'hA5A5A5A5;
  end
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    q = hrdata;
  endtask
endmodule

// [test_charger_control_status_logic.sv]
// Purpose: self-checking bench for ccsl_top
// Assumes: short boost wait and blink counts
// Notes:   comparator levels driven as plain levels
`timescale 1ns/1ps
module test_charger_control_status_logic;
  localparam int WAIT = 20;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, charge_params;
  logic        boost_request_pin, charge_enable_n;
  logic        cmp_bat_above_low, cmp_bus_below_sleep, cmp_temp_in_boost_win;
  logic        cmp_boost_fault, cmp_sys_at_min, cmp_input_current_reg;
  logic        cmp_input_voltage_reg, cmp_sys_below_bat, cmp_bat_below_depl;
  logic        cmp_chg_below_term, cmp_bat_above_rechg_hi;
  logic        cmp_bat_above_rechg_lo, cmp_converter_on;
  logic        cmp_thermistor_fault, cmp_timer_fault;
  logic        boost_enable, boost_current_high, charge_current_cut;
  logic        battery_switch, charge_active, stat_out, stat_oe;
  logic        host_alert_n;
  logic [3:0]  boost_voltage_select;
  logic [2:0]  sys_min_select;
  int          n_mismatch = 0;
  int          n_tests = 0;
  logic [31:0] q;

  ccsl_top #(.BOOST_WAIT_CYC(WAIT), .BLINK_CYC(8), .ALERT_CYC(16)) ccsl_top_i
  (
    .hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .boost_request_pin, .charge_enable_n, .cmp_bat_above_low,
    .cmp_bus_below_sleep, .cmp_temp_in_boost_win, .cmp_boost_fault,
    .cmp_sys_at_min, .cmp_input_current_reg, .cmp_input_voltage_reg,
    .cmp_sys_below_bat, .cmp_bat_below_depl, .cmp_bat_above_short(1'b0),
    .cmp_chg_below_term, .cmp_bat_above_rechg_hi, .cmp_bat_above_rechg_lo,
    .cmp_converter_on, .cmp_thermistor_fault, .cmp_timer_fault,
    .boost_enable, .boost_current_high, .boost_voltage_select,
    .sys_min_select, .charge_current_cut, .battery_switch, .charge_active,
    .charge_params, .stat_out, .stat_oe, .host_alert_n
  );
  ccsl_host ccsl_host_i
  (
    .hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata
  );

  always #2.5 hclk = ~hclk;

  task results;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] act, input logic [31:0] exp);
    n_tests++;
    if (act !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    ccsl_host_i.xfer(1'b1, a, d, q);
  endtask
  task rd(input logic [11:0] a);
    ccsl_host_i.xfer(1'b0, a, 32'h0, q);
  endtask
  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task phase(input logic [1:0] exp);
    tick(8);
    rd(12'h00C);
    chk(q[5:4], exp);
  endtask

  task t_reset;
    rd(12'h000);
    chk(q, 32'h0000001A);
    rd(12'h004);
    chk(q, 32'h0041A777);
    rd(12'h008);
    chk(q, 32'h00000090);
    rd(12'h014);
    chk(q, 32'h0);
    chk(hresp, 32'h0);
    chk(sys_min_select, 32'h5);
    chk(boost_voltage_select, 32'h9);
    chk(charge_params, 32'h0041A777);
    $display("test reset done");
  endtask
  task t_cfg;
    wr(12'h000, 32'h00000017);
    wr(12'h008, 32'h000000F0);
    tick(2);
    chk(boost_current_high, 32'h1);
    chk(sys_min_select, 32'h3);
    chk(boost_voltage_select, 32'hF);
    $display("test config done");
  endtask
  task t_boost;
    cmp_bat_above_low <= 1'b1;
    cmp_bus_below_sleep <= 1'b1;
    cmp_temp_in_boost_win <= 1'b1;
    wr(12'h000, 32'h0000002A);
    boost_request_pin <= 1'b1;
    tick(WAIT / 2);
    chk(boost_enable, 32'h0);
    for (int i = 0; i < 60 && boost_enable !== 1'b1; i++) @(posedge hclk);
    chk(boost_enable, 32'h1);
    rd(12'h00C);
    chk(q[7:6], 32'h3);
    cmp_temp_in_boost_win <= 1'b0;
    tick(8);
    chk(boost_enable, 32'h0);
    wr(12'h008, 32'h0000009C);
    for (int i = 0; i < 60 && boost_enable !== 1'b1; i++) @(posedge hclk);
    chk(boost_enable, 32'h1);
    cmp_boost_fault <= 1'b1;
    tick(1);
    cmp_boost_fault <= 1'b0;
    for (int i = 0; i < 8 && host_alert_n !== 1'b0; i++) @(posedge hclk);
    chk(host_alert_n, 32'h0);
    rd(12'h010);
    chk(q[6], 32'h1);
    rd(12'h010);
    chk(q[6], 32'h0);
    wr(12'h000, 32'h0000001A);
    tick(6);
    chk(boost_enable, 32'h0);
    rd(12'h00C);
    chk(q[7:6], 32'h0);
    boost_request_pin <= 1'b0;
    $display("test boost done");
  endtask
  task t_dpm;
    cmp_input_voltage_reg <= 1'b1;
    cmp_sys_at_min <= 1'b1;
    tick(6);
    chk(charge_current_cut, 32'h1);
    rd(12'h00C);
    chk(q[3], 32'h1);
    chk(q[0], 32'h1);
    cmp_input_voltage_reg <= 1'b0;
    cmp_input_current_reg <= 1'b1;
    tick(6);
    chk(charge_current_cut, 32'h1);
    cmp_input_current_reg <= 1'b0;
    cmp_sys_at_min <= 1'b0;
    tick(6);
    chk(charge_current_cut, 32'h0);
    rd(12'h00C);
    chk(q[3:0], 32'h0);
    $display("test power limit done");
  endtask
  task t_charge;
    logic last;
    int   n;
    cmp_bat_above_low <= 1'b0;
    cmp_converter_on <= 1'b1;
    phase(2'h1);
    chk(stat_oe, 32'h1);
    chk(charge_active, 32'h1);
    cmp_bat_above_low <= 1'b1;
    phase(2'h2);
    cmp_bat_above_rechg_lo <= 1'b1;
    cmp_bat_above_rechg_hi <= 1'b1;
    cmp_chg_below_term <= 1'b1;
    for (int i = 0; i < 12 && host_alert_n !== 1'b0; i++) @(posedge hclk);
    chk(host_alert_n, 32'h0);
    phase(2'h3);
    chk(stat_oe, 32'h0);
    wr(12'h000, 32'h0000011A);
    cmp_bat_above_rechg_lo <= 1'b0;
    phase(2'h3);
    cmp_bat_above_rechg_hi <= 1'b0;
    cmp_chg_below_term <= 1'b0;
    phase(2'h2);
    charge_enable_n <= 1'b1;
    phase(2'h0);
    chk(stat_oe, 32'h0);
    charge_enable_n <= 1'b0;
    phase(2'h2);
    wr(12'h000, 32'h0000031A);
    phase(2'h0);
    chk(battery_switch, 32'h0);
    wr(12'h000, 32'h0000011A);
    phase(2'h2);
    cmp_thermistor_fault <= 1'b1;
    phase(2'h0);
    n = 0;
    last = stat_oe;
    repeat (40)
    begin
      @(posedge hclk);
      if (stat_oe !== last)
        n++;
      last = stat_oe;
    end
    chk(n >= 2, 32'h1);
    chk(stat_out, 32'h0);
    cmp_thermistor_fault <= 1'b0;
    cmp_timer_fault <= 1'b1;
    phase(2'h0);
    chk(charge_active, 32'h0);
    cmp_timer_fault <= 1'b0;
    cmp_converter_on <= 1'b0;
    charge_enable_n <= 1'b1;
    $display("test charge done");
  endtask
  task t_supp;
    cmp_sys_below_bat <= 1'b1;
    tick(8);
    chk(battery_switch, 32'h1);
    cmp_bat_below_depl <= 1'b1;
    tick(8);
    chk(battery_switch, 32'h0);
    $display("test supplement done");
  endtask

  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {boost_request_pin, charge_enable_n, cmp_bat_above_low,
     cmp_bus_below_sleep, cmp_temp_in_boost_win, cmp_boost_fault,
     cmp_sys_at_min, cmp_input_current_reg, cmp_input_voltage_reg,
     cmp_sys_below_bat, cmp_bat_below_depl, cmp_chg_below_term,
     cmp_bat_above_rechg_hi, cmp_bat_above_rechg_lo, cmp_converter_on,
     cmp_thermistor_fault, cmp_timer_fault} = '0;
    tick(10);
    hresetn <= 1'b1;
    tick(1);
    t_reset;
    t_cfg;
    t_boost;
    t_dpm;
    t_charge;
    t_supp;
    results;
  end
  initial
  begin
    #20000;
    n_mismatch++;
    results;
  end
endmodule
